// [pph_regs.vh]
`ifndef PPH_REGS_VH
`define PPH_REGS_VH
// Register select codes on the host address lines
`define PPH_ADDR_SPI      2'h0
`define PPH_ADDR_DISP     2'h1
`define PPH_ADDR_DBG      2'h2
`define PPH_ADDR_BOOT     2'h3
// Reset values
`define PPH_SPI_RST       8'h60
`define PPH_DISP_RST      8'h00
`define PPH_DBG_RST       7'h62
`define PPH_PSEL_RST      1'h0
// Control register 0 fields
`define PPH_SPI_CLK       0
`define PPH_SPI_MOSI_LVL  1
`define PPH_SPI_MISO_LVL  2
`define PPH_SPI_MOSI_DIR  3
`define PPH_SPI_MISO_DIR  4
`define PPH_SPI_EE_SEL    5
`define PPH_SPI_CODEC_SEL 6
`define PPH_SPI_DSP_SEL   7
// Control register 2 fields
`define PPH_DBG_GPIO_LVL  0
`define PPH_DBG_GPIO_DIR  1
`define PPH_DBG_CLK       2
`define PPH_DBG_DATA_LVL  3
`define PPH_DBG_DATA_DIR  4
`define PPH_DBG_LE_LOW    5
`define PPH_DBG_LE_HIGH   6
// Control register 3 fields
`define PPH_BOOT_PSEL     0
`define PPH_BOOT_PIN      1
`endif

// [pph_host_port.v]
`timescale 1ns/1ns
`include "pph_regs.vh"
// How it works
// - Four registers of up to 8 bits (register 2 keeps 7, register 3 keeps 2), selected by address lines
// - Register 0: clock, levels, directions, selects
// - Direction bit 1 drives line, 0 input
// - Register 0 resets to 0110 0000
// - Register 1 display data, resets zero
// - Register 2 GPIO, debug, latches; resets x1100010
// - Debug direction routes debug data either way
// - GPIO direction drives or senses DSP line
// - Both display latch enables active low
// - Register 3: port select, boot level
// - Boot bit keeps its value through reset
// - Status 0: MOSI, MISO, service request
// - Status 1: three board switch states and sample rate flag
// - Status 2: debug input, GPIO input
// - Status 3: four DSP command flags
// - DSP request low to send, high to receive
module pph_host_port (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [7:0] host_data,
  input  wire       host_strobe_n,
  input  wire [1:0] host_addr,
  output reg  [3:0] host_status,
  output reg        serial_clock_bit,
  output reg        mosi_out,
  output reg        mosi_oe,
  input  wire       mosi_in,
  output reg        miso_out,
  output reg        miso_oe,
  input  wire       miso_in,
  output reg        eeprom_select_n,
  output reg        codec_select_n,
  output reg        dsp_select_n,
  output reg  [7:0] display_data,
  output reg        low_digit_latch_n,
  output reg        high_digit_latch_n,
  output reg        gpio_out,
  output reg        gpio_oe,
  input  wire       gpio_sense,
  output reg        debug_clock_bit,
  output reg        debug_out,
  output reg        debug_oe,
  input  wire       debug_sense,
  output reg        external_port_select_n,
  output reg        dsp_boot_level,
  input  wire       service_request_n,
  input  wire       local_switch,
  input  wire       master_switch,
  input  wire       audio_format_switch,
  input  wire       sample_rate_flag,
  input  wire [3:0] command_flags
);

  reg       rst_meta_q;
  reg       rst_sync_q;
  reg [7:0] spi_pin_control_q;
  reg [7:0] segment_display_data_q;
  reg [6:0] debug_gpio_display_control_q;
  reg       port_select_q;
  reg       boot_level_q;
  reg       strobe_q;
  reg [3:0] status_d;

  wire wr_pulse = ~host_strobe_n & strobe_q;

  // Address decode shared by every register and the boot bit
  function pph_hit;
    input       wr;
    input [1:0] addr;
    input [1:0] code;
    begin
      pph_hit = wr & (addr == code);
    end
  endfunction

  wire wr_spi  = pph_hit(wr_pulse, host_addr, `PPH_ADDR_SPI);
  wire wr_disp = pph_hit(wr_pulse, host_addr, `PPH_ADDR_DISP);
  wire wr_dbg  = pph_hit(wr_pulse, host_addr, `PPH_ADDR_DBG);
  wire wr_boot = pph_hit(wr_pulse, host_addr, `PPH_ADDR_BOOT);

  // Synchronised reset release
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Edge of strobe so one assertion writes once
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= host_strobe_n;
    end
  end

  // Each register has its own process; unaddressed ones hold
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      spi_pin_control_q <= `PPH_SPI_RST;
    end else if (wr_spi) begin
      spi_pin_control_q <= host_data;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      segment_display_data_q <= `PPH_DISP_RST;
    end else if (wr_disp) begin
      segment_display_data_q <= host_data;
    end
  end

  // Reserved bit 7 is not stored
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      debug_gpio_display_control_q <= `PPH_DBG_RST;
    end else if (wr_dbg) begin
      debug_gpio_display_control_q <= host_data[6:0];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      port_select_q <= `PPH_PSEL_RST;
    end else if (wr_boot) begin
      port_select_q <= host_data[`PPH_BOOT_PSEL];
    end
  end

  // Boot level has no reset so it survives a board reset
  always @(posedge sys_clk) begin
    if (wr_boot) begin
      boot_level_q <= host_data[`PPH_BOOT_PIN];
    end
  end

  always @* begin
    case (host_addr)
      `PPH_ADDR_SPI: begin
        status_d = {1'b0, service_request_n, miso_in, mosi_in};
      end
      `PPH_ADDR_DISP: begin
        status_d = {sample_rate_flag, audio_format_switch,
                    master_switch, local_switch};
      end
      `PPH_ADDR_DBG: begin
        status_d = {2'b00, gpio_sense, debug_sense};
      end
      default: begin
        status_d = command_flags;
      end
    endcase
  end

  // Status follows the address one clock later
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      host_status <= 4'h0;
    end else begin
      host_status <= status_d;
    end
  end

  // One flop per pin; costs a cycle of lag behind each write
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      serial_clock_bit <= 1'b0;
    end else begin
      serial_clock_bit <= spi_pin_control_q[`PPH_SPI_CLK];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mosi_out <= 1'b0;
    end else begin
      mosi_out <= spi_pin_control_q[`PPH_SPI_MOSI_LVL];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mosi_oe <= 1'b0;
    end else begin
      mosi_oe <= spi_pin_control_q[`PPH_SPI_MOSI_DIR];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      miso_out <= 1'b0;
    end else begin
      miso_out <= spi_pin_control_q[`PPH_SPI_MISO_LVL];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= spi_pin_control_q[`PPH_SPI_MISO_DIR];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      eeprom_select_n <= 1'b1;
    end else begin
      eeprom_select_n <= spi_pin_control_q[`PPH_SPI_EE_SEL];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      codec_select_n <= 1'b1;
    end else begin
      codec_select_n <= spi_pin_control_q[`PPH_SPI_CODEC_SEL];
    end
  end

  // Low in reset so the DSP wakes in its serial mode
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      dsp_select_n <= 1'b0;
    end else begin
      dsp_select_n <= spi_pin_control_q[`PPH_SPI_DSP_SEL];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      display_data <= 8'h00;
    end else begin
      display_data <= segment_display_data_q;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      low_digit_latch_n <= 1'b1;
    end else begin
      low_digit_latch_n <=
        debug_gpio_display_control_q[`PPH_DBG_LE_LOW];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      high_digit_latch_n <= 1'b1;
    end else begin
      high_digit_latch_n <=
        debug_gpio_display_control_q[`PPH_DBG_LE_HIGH];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gpio_out <= 1'b0;
    end else begin
      gpio_out <= debug_gpio_display_control_q[`PPH_DBG_GPIO_LVL];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gpio_oe <= 1'b1;
    end else begin
      gpio_oe <= debug_gpio_display_control_q[`PPH_DBG_GPIO_DIR];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      debug_clock_bit <= 1'b0;
    end else begin
      debug_clock_bit <= debug_gpio_display_control_q[`PPH_DBG_CLK];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      debug_out <= 1'b0;
    end else begin
      debug_out <= debug_gpio_display_control_q[`PPH_DBG_DATA_LVL];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      debug_oe <= 1'b0;
    end else begin
      debug_oe <= debug_gpio_display_control_q[`PPH_DBG_DATA_DIR];
    end
  end

  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      external_port_select_n <= 1'b0;
    end else begin
      external_port_select_n <= port_select_q;
    end
  end

  // No reset: the DSP samples this pin while the board resets
  // Unwritten boot bit is unknown until the host sets it
  always @(posedge sys_clk) begin
    dsp_boot_level <= boot_level_q;
  end

endmodule // pph_host_port

// [pph_host_port_chk.sv]
`timescale 1ns/1ns
module pph_host_port_chk (
  input wire       sys_clk,
  input wire       rst_n,
  input wire [7:0] host_data,
  input wire       host_strobe_n,
  input wire [1:0] host_addr,
  input wire [3:0] host_status,
  input wire [3:0] command_flags,
  input wire [7:0] display_data,
  input wire       dsp_select_n,
  input wire       codec_select_n,
  input wire       eeprom_select_n,
  input wire       gpio_oe,
  input wire       high_digit_latch_n,
  input wire       external_port_select_n,
  input wire       dsp_boot_level
);
  reg [2:0] up_q;
  reg       rst_hold_q;
  // Reset checks wait one edge so the async clear has landed
  always @(posedge sys_clk)
    rst_hold_q <= !rst_n;
  // Trails the two-flop release by one edge so checks start clean
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      up_q <= 3'h0;
    else
      up_q <= {up_q[1:0], 1'b1};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!up_q[2]);
  sel_wr_a: assert property ($fell(host_strobe_n) && host_addr == 2'h0
    |-> ##2 {dsp_select_n, codec_select_n, eeprom_select_n}
    == $past(host_data[7:5], 2)) else $error("select write");
  disp_wr_a: assert property ($fell(host_strobe_n) && host_addr == 2'h1
    |-> ##2 display_data == $past(host_data, 2)) else $error("display write");
  dbg_wr_a: assert property ($fell(host_strobe_n) && host_addr == 2'h2
    |-> ##2 {high_digit_latch_n, gpio_oe} == {$past(host_data[6], 2),
    $past(host_data[1], 2)}) else $error("debug write");
  boot_wr_a: assert property ($fell(host_strobe_n) && host_addr == 2'h3
    |-> ##2 {dsp_boot_level, external_port_select_n}
    == $past(host_data[1:0], 2)) else $error("boot write");
  flag_rd_a: assert property (host_addr == 2'h3
    |=> host_status == $past(command_flags)) else $error("flag read");
  no_wr_a: assert property (!$fell(host_strobe_n)
    |-> ##2 $stable(display_data)) else $error("stray write");
  rst_val_a: assert property (disable iff (1'b0) rst_hold_q && !rst_n
    |-> display_data == 8'h00 && !dsp_select_n && codec_select_n
    && eeprom_select_n && gpio_oe && high_digit_latch_n
    && !external_port_select_n) else $error("reset values");
  boot_keep_a: assert property (disable iff (1'b0)
    $past(up_q[2]) && !rst_n |-> $stable(dsp_boot_level))
    else $error("boot level lost");
  cover property ($fell(host_strobe_n) && host_addr == 2'h3);
  cover property (host_addr == 2'h1 ##1 host_addr == 2'h2);
  cover property (disable iff (1'b0) $past(up_q[2]) && !rst_n);
endmodule // pph_host_port_chk

// [pph_pc_host.sv]
`timescale 1ns/1ns
module pph_pc_host (
  input  wire       sys_clk,
  output reg  [7:0] host_data = 8'h00,
  output reg        host_strobe_n = 1'b1,
  output reg  [1:0] host_addr = 2'h0
);
  // One byte per strobe; serial framing is built by the caller
  task wr(input [1:0] a, input [7:0] d);
    @(posedge sys_clk) #2;
    host_addr = a;
    host_data = d;
    host_strobe_n = 1'b0;
    @(posedge sys_clk) #2;
    host_strobe_n = 1'b1;
    // Port data moves on at once; the latch must not lag
    host_data = ~d;
    @(posedge sys_clk) #1;
  endtask
  task look(input [1:0] a);
    @(posedge sys_clk) #2;
    host_addr = a;
  endtask
endmodule // pph_pc_host

// [pph_host_port_tb.sv]
`timescale 1ns/1ns
module pph_host_port_tb;
  typedef struct {bit k; logic [24:0] e; logic [24:0] m; int t;} pph_note_t;
  pph_note_t q[$];
  int seed = 94688, cyc = 0, error_cnt = 0, check_count = 0;
  logic sys_clk = 1'b0, rst_n = 1'b0, mosi_in, miso_in, gpio_sense;
  logic debug_sense, service_request_n, local_switch, master_switch;
  logic audio_format_switch, sample_rate_flag;
  logic [3:0] command_flags;
  logic [24:0] sh;
  wire [7:0] host_data, display_data;
  wire [1:0] host_addr;
  wire [3:0] host_status;
  wire host_strobe_n, serial_clock_bit, mosi_out, mosi_oe, miso_out, miso_oe;
  wire eeprom_select_n, codec_select_n, dsp_select_n, low_digit_latch_n;
  wire high_digit_latch_n, gpio_out, gpio_oe, debug_clock_bit, debug_out;
  wire debug_oe, external_port_select_n, dsp_boot_level;
  wire [24:0] pins = {dsp_boot_level, external_port_select_n,
    high_digit_latch_n, low_digit_latch_n, debug_oe, debug_out,
    debug_clock_bit, gpio_oe, gpio_out, display_data, dsp_select_n,
    codec_select_n, eeprom_select_n, miso_oe, mosi_oe, miso_out, mosi_out,
    serial_clock_bit};
  pph_pc_host p (.sys_clk, .host_data, .host_strobe_n, .host_addr);
  pph_host_port dut (.sys_clk, .rst_n, .host_data, .host_strobe_n,
    .host_addr, .host_status, .serial_clock_bit, .mosi_out, .mosi_oe,
    .mosi_in, .miso_out, .miso_oe, .miso_in, .eeprom_select_n,
    .codec_select_n, .dsp_select_n, .display_data, .low_digit_latch_n,
    .high_digit_latch_n, .gpio_out, .gpio_oe, .gpio_sense, .debug_clock_bit,
    .debug_out, .debug_oe, .debug_sense, .external_port_select_n,
    .dsp_boot_level, .service_request_n, .local_switch, .master_switch,
    .audio_format_switch, .sample_rate_flag, .command_flags);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  task chk_pins(input logic [24:0] e, input logic [24:0] m);
    check_count++;
    if ((pins & m) !== (e & m)) begin
      error_cnt++;
      $display("unexpected pins %h want %h at %0t", pins, e, $time);
    end
  endtask
  task chk_status(input logic [3:0] e, input logic [3:0] m);
    check_count++;
    if ((host_status & m) !== (e & m)) begin
      error_cnt++;
      $display("unexpected status %h want %h at %0t", host_status, e, $time);
    end
  endtask
  task put(input [1:0] a, input [7:0] d);
    p.wr(a, d);
    case (a)
      2'h0: sh[7:0] = d;
      2'h1: sh[15:8] = d;
      2'h2: sh[22:16] = d[6:0];
      default: sh[24:23] = d[1:0];
    endcase
    q.push_back('{1'b0, sh, '1, cyc + 1});
  endtask
  task look(input [1:0] a);
    logic [3:0] e;
    p.look(a);
    {command_flags, sample_rate_flag, audio_format_switch, master_switch,
      local_switch, service_request_n, debug_sense, gpio_sense, miso_in,
      mosi_in} = 13'($random(seed));
    case (a)
      2'h0: e = {1'b0, service_request_n, miso_in, mosi_in};
      2'h1: e = {sample_rate_flag, audio_format_switch, master_switch,
        local_switch};
      2'h2: e = {2'h0, gpio_sense, debug_sense};
      default: e = command_flags;
    endcase
    q.push_back('{1'b1, {21'h0, e}, {21'h0, a == 2'h0 ? 4'h7 :
      a == 2'h2 ? 4'h3 : 4'hf}, cyc + 1});
  endtask
  localparam int cfg_len = 16 * 3 + 1;
  task spi_byte(input [2:0] s, input [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      put(2'h0, {s, 2'h1, 1'b0, b[i], 1'b0});
      put(2'h0, {s, 2'h1, 1'b0, b[i], 1'b1});
      look(2'h0);
    end
  endtask
  task ee_block(input [15:0] a, input int n);
    spi_byte(3'h6, 8'h02);
    spi_byte(3'h6, a[15:8]);
    spi_byte(3'h6, a[7:0]);
    for (int k = 0; k < n; k++)
      spi_byte(3'h6, a + k == 0 ? 8'h00 : 8'($random(seed)));
    put(2'h0, 8'he0);
  endtask
  // Boot level is unknown before its first write, so masked then
  task rst(input int n, input logic [24:0] m);
    @(posedge sys_clk) #2;
    rst_n = 1'b0;
    sh = {sh[24], 1'b0, 7'h62, 8'h00, 8'h60};
    q.push_back('{1'b0, sh, m, cyc + 1});
    repeat (n) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial forever begin
    @(posedge sys_clk) #1;
    while (q.size() > 0 && q[0].t <= cyc) begin
      if (q[0].k)
        chk_status(q[0].e[3:0], q[0].m[3:0]);
      else
        chk_pins(q[0].e, q[0].m);
      void'(q.pop_front());
    end
  end
  initial begin
    {command_flags, sample_rate_flag, audio_format_switch, master_switch,
      local_switch, service_request_n, debug_sense, gpio_sense, miso_in,
      mosi_in} = 13'h0000;
    rst(11, 25'h0ff_ffff);
    for (int i = 0; i < 16; i++)
      put(2'h3 - i[1:0], 8'($random(seed)));
    for (int i = 0; i < 8; i++)
      look(i[1:0]);
    ee_block(16'h0000, 4);
    ee_block(16'h0100, 32);
    ee_block(16'h0120, cfg_len - 32);
    spi_byte(3'h6, 8'h04);
    put(2'h0, 8'he0);
    put(2'h3, 8'h03);
    put(2'h0, 8'h60);
    rst(3, 25'h1ff_ffff);
    spi_byte(3'h3, 8'h00);
    put(2'h1, 8'ha5);
    for (int i = 0; i < 20 && q.size() > 0; i++)
      @(posedge sys_clk);
    if (q.size() > 0) begin
      error_cnt++;
      $display("unexpected %0d notes left at %0t", q.size(), $time);
    end
    close_out;
  end
endmodule // pph_host_port_tb
bind pph_host_port pph_host_port_chk u_chk (.*);
